// ==== src/asrc_defines.svh ====
`ifndef ASRC_DEFINES_SVH
`define ASRC_DEFINES_SVH

`define ASRC_CLK_PERIOD_NS 50
`define ASRC_ADDR_W 15
`define ASRC_DATA_W 8

// Device timing figures in ns
`define ASRC_T_ADDR_ACCESS_NS 25
`define ASRC_T_MIN_CYCLE_NS 25
`define ASRC_T_OE_ACCESS_NS 9
`define ASRC_T_WRITE_PULSE_NS 20
`define ASRC_T_WRITE_RECOVERY_NS 5
`define ASRC_T_WRITE_FLOAT_NS 9
`define ASRC_T_SELECT_FLOAT_NS 10

// Least times rounded up to cycles, never below one
`define ASRC_CYC_UP(ns) ((((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS) < 1 ? 1 : \
    (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS))
`define ASRC_CYC_READ `ASRC_CYC_UP(`ASRC_T_ADDR_ACCESS_NS)
`define ASRC_CYC_WRITE `ASRC_CYC_UP(`ASRC_T_WRITE_PULSE_NS)
`define ASRC_CYC_RECOVER `ASRC_CYC_UP(`ASRC_T_WRITE_RECOVERY_NS)
`define ASRC_CYC_FLOAT `ASRC_CYC_UP(`ASRC_T_SELECT_FLOAT_NS)
`define ASRC_CNT_W 3

`endif

// ==== src/asrc_pkg.sv ====
package asrc_pkg;
    typedef enum logic [2:0] {
        ASRC_IDLE,
        ASRC_READ,
        ASRC_WSETUP,
        ASRC_WPULSE,
        ASRC_RECOVER
    } asrc_state_e;
endpackage : asrc_pkg

// ==== src/asrc_sync.sv ====
module asrc_sync #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_sync_out;

    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule : asrc_sync

// ==== src/asrc_host.sv ====
// Notes on behaviour
// - Read drives select and output enable low, chip enable and write strobe high.
// - Back-to-back reads raise select and output enable between accesses, select for one cycle; chip enable stays high.
// - Select and chip enable are valid no later than the address edge.
// - Write drives write strobe and select low, chip enable high.
// - Between writes one control goes inactive for at least 5 ns.
// - Write condition held 20 ns; address valid 20 ns before write end.
// - Write data valid 15 ns before write end; 0 ns hold suffices.
// - Address stays stable during the whole write.
`include "asrc_defines.svh"

module asrc_host (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [`ASRC_ADDR_W-1:0] req_addr,
    input wire logic [`ASRC_DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [`ASRC_DATA_W-1:0] rsp_rdata,
    output logic [`ASRC_ADDR_W-1:0] ram_addr,
    output logic select_n,
    output logic chip_enable,
    output logic write_strobe_n,
    output logic output_enable_n,
    input wire logic [`ASRC_DATA_W-1:0] ram_dq_in,
    output logic [`ASRC_DATA_W-1:0] ram_dq_out,
    output logic ram_dq_oe_n
);
    // ****************************************
    // State
    // ****************************************
    asrc_pkg::asrc_state_e state;
    asrc_pkg::asrc_state_e next_state;
    logic [`ASRC_CNT_W-1:0] cnt;
    logic [`ASRC_CNT_W-1:0] next_cnt;
    logic [`ASRC_DATA_W-1:0] dq_sync;
    logic next_req_ready;
    logic next_rsp_valid;
    logic [`ASRC_DATA_W-1:0] next_rsp_rdata;
    logic [`ASRC_ADDR_W-1:0] next_ram_addr;
    logic next_select_n;
    logic next_chip_enable;
    logic next_write_strobe_n;
    logic next_output_enable_n;
    logic [`ASRC_DATA_W-1:0] next_ram_dq_out;
    logic next_ram_dq_oe_n;

    // ****************************************
    // Read data synchroniser
    // ****************************************
    asrc_sync #(
        .W(`ASRC_DATA_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in(ram_dq_in),
        .sync_out(dq_sync)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_req_ready = req_ready;
        next_rsp_valid = 1'b0;
        next_rsp_rdata = rsp_rdata;
        next_ram_addr = ram_addr;
        next_select_n = select_n;
        next_chip_enable = chip_enable;
        next_write_strobe_n = write_strobe_n;
        next_output_enable_n = output_enable_n;
        next_ram_dq_out = ram_dq_out;
        next_ram_dq_oe_n = ram_dq_oe_n;
        unique case (state)
            asrc_pkg::ASRC_IDLE: begin
                if (req_valid && req_ready) begin
                    next_req_ready = 1'b0;
                    next_ram_addr = req_addr;
                    next_select_n = 1'b0;
                    next_chip_enable = 1'b1;
                    next_write_strobe_n = 1'b1;
                    if (req_write) begin
                        next_output_enable_n = 1'b1;
                        next_ram_dq_out = req_wdata;
                        next_ram_dq_oe_n = 1'b0;
                        next_state = asrc_pkg::ASRC_WSETUP;
                    end else begin
                        next_output_enable_n = 1'b0;
                        next_ram_dq_oe_n = 1'b1;
                        next_cnt = `ASRC_CNT_W'(`ASRC_CYC_READ + 2);
                        next_state = asrc_pkg::ASRC_READ;
                    end
                end
            end
            asrc_pkg::ASRC_READ: begin
                if (cnt == `ASRC_CNT_W'(1)) begin
                    next_rsp_valid = 1'b1;
                    next_rsp_rdata = dq_sync;
                    next_req_ready = 1'b1;
                    next_cnt = `ASRC_CNT_W'(`ASRC_CYC_FLOAT);
                    next_state = asrc_pkg::ASRC_RECOVER;
                    next_output_enable_n = 1'b1;
                end else begin
                    next_cnt = cnt - `ASRC_CNT_W'(1);
                end
            end
            asrc_pkg::ASRC_WSETUP: begin
                next_write_strobe_n = 1'b0;
                next_cnt = `ASRC_CNT_W'(`ASRC_CYC_WRITE);
                next_state = asrc_pkg::ASRC_WPULSE;
            end
            asrc_pkg::ASRC_WPULSE: begin
                if (cnt == `ASRC_CNT_W'(1)) begin
                    next_write_strobe_n = 1'b1;
                    next_cnt = `ASRC_CNT_W'(`ASRC_CYC_RECOVER + `ASRC_CYC_FLOAT);
                    next_state = asrc_pkg::ASRC_RECOVER;
                end else begin
                    next_cnt = cnt - `ASRC_CNT_W'(1);
                end
            end
            asrc_pkg::ASRC_RECOVER: begin
                next_select_n = 1'b1;
                next_ram_dq_oe_n = 1'b1;
                if (cnt == `ASRC_CNT_W'(1)) begin
                    next_req_ready = 1'b1;
                    next_state = asrc_pkg::ASRC_IDLE;
                end else begin
                    next_cnt = cnt - `ASRC_CNT_W'(1);
                end
            end
        endcase
        if (state == asrc_pkg::ASRC_READ && cnt == `ASRC_CNT_W'(1)) begin
            next_req_ready = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= asrc_pkg::ASRC_IDLE;
            cnt <= '0;
            req_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            ram_addr <= '0;
            select_n <= 1'b1;
            chip_enable <= 1'b0;
            write_strobe_n <= 1'b1;
            output_enable_n <= 1'b1;
            ram_dq_out <= '0;
            ram_dq_oe_n <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp_rdata <= next_rsp_rdata;
            ram_addr <= next_ram_addr;
            select_n <= next_select_n;
            chip_enable <= next_chip_enable;
            write_strobe_n <= next_write_strobe_n;
            output_enable_n <= next_output_enable_n;
            ram_dq_out <= next_ram_dq_out;
            ram_dq_oe_n <= next_ram_dq_oe_n;
        end
    end
endmodule : asrc_host

// ==== verification/asrc_host_assertions.sv ====
`include "asrc_defines.svh"
module asrc_host_chk (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [`ASRC_ADDR_W-1:0] req_addr,
    input wire logic [`ASRC_DATA_W-1:0] req_wdata,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [`ASRC_DATA_W-1:0] rsp_rdata,
    input wire logic [`ASRC_ADDR_W-1:0] ram_addr,
    input wire logic select_n,
    input wire logic chip_enable,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [`ASRC_DATA_W-1:0] ram_dq_in,
    input wire logic [`ASRC_DATA_W-1:0] ram_dq_out,
    input wire logic ram_dq_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic take;
    assign take = req_valid && req_ready;
    AST_READ_CTRL: assert property (!output_enable_n |-> !select_n && chip_enable && write_strobe_n)
        else $error("read controls wrong");
    AST_RSP_LAT: assert property (take && !req_write |-> ##4 rsp_valid)
        else $error("read answer late");
    AST_RSP_WAIT: assert property (rsp_valid |-> !$past(output_enable_n, 1) && !$past(output_enable_n, 3))
        else $error("read sampled too early");
    AST_READY_BACK: assert property (take |=> !req_ready [*4] ##1 req_ready)
        else $error("ready spacing wrong");
    AST_WRITE_CTRL: assert property (!write_strobe_n |-> !select_n && chip_enable && !ram_dq_oe_n)
        else $error("write controls wrong");
    AST_WPULSE: assert property ($fell(write_strobe_n) |-> !select_n && chip_enable ##1 write_strobe_n && !select_n)
        else $error("write pulse length wrong");
    AST_DATA_SETUP: assert property ($rose(write_strobe_n) |-> $stable(ram_dq_out) && !$past(ram_dq_oe_n, 2))
        else $error("write data not held");
    AST_ADDR_STABLE: assert property (!select_n && !$fell(select_n) |-> $stable(ram_addr))
        else $error("address moved in access");
    AST_GAP: assert property ($rose(write_strobe_n) |=> select_n [*2])
        else $error("select gap too short");
    AST_NO_FIGHT: assert property (!ram_dq_oe_n |-> output_enable_n)
        else $error("bus contention");
    COV_READ: cover property (take && !req_write);
    COV_WRITE: cover property (take && req_write);
    COV_RSP: cover property (rsp_valid);
endmodule : asrc_host_chk
bind asrc_host asrc_host_chk chk (.*);

// ==== verification/asrc_ram_model.sv ====
`include "asrc_defines.svh"
module asrc_ram_model (
    input wire logic sys_clk,
    input wire logic [`ASRC_ADDR_W-1:0] ram_addr,
    input wire logic select_n,
    input wire logic chip_enable,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [`ASRC_DATA_W-1:0] ram_dq_out,
    input wire logic ram_dq_oe_n,
    output logic [`ASRC_DATA_W-1:0] ram_dq_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [`ASRC_DATA_W-1:0] mem [0:(2**`ASRC_ADDR_W)-1];
    logic [`ASRC_DATA_W-1:0] rd_q;
    logic [`ASRC_DATA_W-1:0] float_pat = 8'h5a;
    logic drv;
    wire wr_act = !select_n && chip_enable && !write_strobe_n;
    wire rd_en = !select_n && chip_enable && write_strobe_n && !output_enable_n;
    assign #9 drv = rd_en;
    assign #25 rd_q = mem[ram_addr];
    always @(negedge wr_act) mem[ram_addr] = ram_dq_out;
    always @(posedge sys_clk) float_pat <= float_pat + 8'h3b;
    assign ram_dq_in = !ram_dq_oe_n ? ram_dq_out : (drv ? rd_q : float_pat);
endmodule : asrc_ram_model

// ==== verification/async_sram_read_write_control_bench.sv ====
`include "asrc_defines.svh"
module async_sram_read_write_control_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 0, sys_rst = 1, req_valid = 0, req_write = 0;
    logic [14:0] req_addr = 15'h0000;
    logic [7:0] req_wdata = 8'h00;
    logic req_ready, rsp_valid, select_n, chip_enable, write_strobe_n, output_enable_n, ram_dq_oe_n;
    logic [7:0] rsp_rdata, ram_dq_in, ram_dq_out;
    logic [14:0] ram_addr;
    int mismatches = 0, cmp_count = 0, cycles = 0;
    logic [7:0] exp_q [$];
    logic [7:0] shadow [logic [14:0]];
    logic [14:0] addrs [8];
    initial forever #25 sys_clk = ~sys_clk;
    asrc_host dut (.sys_clk, .sys_rst, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready, .rsp_valid,
        .rsp_rdata, .ram_addr, .select_n, .chip_enable, .write_strobe_n, .output_enable_n, .ram_dq_in,
        .ram_dq_out, .ram_dq_oe_n);
    asrc_ram_model ram (.sys_clk, .ram_addr, .select_n, .chip_enable, .write_strobe_n, .output_enable_n,
        .ram_dq_out, .ram_dq_oe_n, .ram_dq_in);
    task conclude;
        $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    task check(input string what, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task issue(input logic w, input logic [14:0] a, input logic [7:0] d);
        {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
        if (w) shadow[a] = d;
        else exp_q.push_back(shadow[a]);
        do @(negedge sys_clk); while (req_ready !== 1'b1);
        @(posedge sys_clk);
        #2;
    endtask : issue
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end
    always @(negedge sys_clk) if (rsp_valid === 1'b1) check("rsp_rdata", exp_q.pop_front(), rsp_rdata);
    initial begin
        void'($urandom(13884));
        repeat (5) @(posedge sys_clk);
        #2 sys_rst = 0;
        foreach (addrs[i]) begin
            addrs[i] = 15'($urandom);
            issue(1'b1, addrs[i], 8'($urandom));
        end
        foreach (addrs[i]) issue(1'b0, addrs[i], 8'h00);
        req_valid = 0;
        $display("test random write then read done");
        issue(1'b1, 15'h0000, 8'hff);
        issue(1'b0, 15'h0000, 8'h00);
        issue(1'b1, 15'h7fff, 8'h00);
        issue(1'b0, 15'h7fff, 8'h00);
        req_valid = 0;
        $display("test boundary interleave done");
        repeat (8) @(posedge sys_clk);
        #2 sys_rst = 1;
        repeat (3) @(posedge sys_clk);
        #2 sys_rst = 0;
        check("select_n", 8'h01, {7'h00, select_n});
        check("req_ready", 8'h01, {7'h00, req_ready});
        check("rsp_rdata", 8'h00, rsp_rdata);
        issue(1'b0, addrs[0], 8'h00);
        req_valid = 0;
        $display("test reset mid run done");
        repeat (10) @(posedge sys_clk);
        check("pending reads", 8'h00, 8'(exp_q.size()));
        conclude();
    end
endmodule : async_sram_read_write_control_bench
